// >>> spi_port_pkg.sv
// Constants, types and register map of the serial register access port.
// Assumes a single 250 MHz system clock; serial pins arrive asynchronously.
// Notes on behaviour
// R1 - One datagram: address byte plus four data bytes
// R2 - Bits travel MSB first, bit 39 to 0
// R3 - Every register uses full 32-bit data field
// R4 - Seven low address bits select the register
// R5 - Bit 39 zero reads, one writes
// R6 - Host adds 0x80 to address for writes
// R7 - Read datagram data bits are ignored
// R8 - Values right aligned, signed as two's complement
// R9 - Write-only, read-write and read-only registers exist
// R10 - Sine table RAM: 8192 entries, 12 bits
// R11 - Separate register addresses for table read, write
// R12 - Table read data arrives one datagram late
// R13 - Host loads whole table after power-up
// R14 - Fixed readable type and version code
// R15 - Masked interrupt condition drives interrupt line low
// R16 - Parameters set only by serial register writes
// R17 - Read-clear and write-clear registers clear themselves
// R18 - Exactly 40 edges; act on complete datagrams
// R19 - Read data shifted out in following datagram
`default_nettype none

package spi_port_pkg;

    localparam int          FRAME_BITS   = 40;
    localparam logic [5:0]  FRAME_CNT    = 6'h28;
    localparam logic [5:0]  CNT_MAX      = 6'h3F;
    localparam int          ADDR_W       = 7;
    localparam int          DATA_W       = 32;
    localparam int          RW_BIT       = 39;
    // Pin idle levels {CS_N, SCK, MOSI}; no false edge after reset
    localparam logic [2:0]  PIN_IDLE     = 3'h4;

    localparam logic [6:0]  ADDR_MODE    = 7'h00;
    localparam logic [6:0]  ADDR_VEL     = 7'h04;
    localparam logic [6:0]  ADDR_STATUS  = 7'h0B;
    localparam logic [6:0]  ADDR_ENC_EVT = 7'h13;
    localparam logic [6:0]  ADDR_IRQ_MSK = 7'h68;
    localparam logic [6:0]  ADDR_IRQ_FLG = 7'h69;
    localparam logic [6:0]  ADDR_LUT_PTR = 7'h6C;
    localparam logic [6:0]  ADDR_LUT_WR  = 7'h6D;
    localparam logic [6:0]  ADDR_LUT_RD  = 7'h6E;
    localparam logic [6:0]  ADDR_TYPE    = 7'h6F;

    localparam int          MODE_W       = 10;
    localparam logic [9:0]  MODE_RST     = 10'h002;
    localparam logic [31:0] VEL_RST      = 32'h0000_0000;
    localparam int          STATUS_W     = 5;
    localparam int          IRQ_W        = 8;
    localparam logic [7:0]  IRQ_MSK_RST  = 8'h00;

    localparam int          LUT_DEPTH    = 8192;
    localparam int          LUT_IDX_W    = 13;
    localparam int          LUT_DAT_W    = 12;

    // Arbitrary neutral identification value
    localparam logic [31:0] TYPE_VERSION = 32'h0000_0A01;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'h0,
        ST_SHIFT  = 2'h1,
        ST_COMMIT = 2'h3
    } link_state_e;

endpackage : spi_port_pkg

`default_nettype wire

// >>> spi_pin_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pins.
// Assumes each bit is an independent level; no bus coherence implied.
`default_nettype none

module spi_pin_sync #(
    parameter int           W       = 3,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] async_i,
    output var  logic [W-1:0] sync_o
);

    logic [W-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= RST_VAL;
            sync_o   <= RST_VAL;
        end else begin
            meta_reg <= async_i;
            sync_o   <= meta_reg;
        end
    end

endmodule : spi_pin_sync

`default_nettype wire

// >>> sine_table_ram.sv
// Flip-flop sine table storage with one write and one registered read port.
// Contents are undefined after power-up until the host loads them.
`default_nettype none

module sine_table_ram
    import spi_port_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 wr_en_i,
    input  wire logic [LUT_IDX_W-1:0] wr_idx_i,
    input  wire logic [LUT_DAT_W-1:0] wr_data_i,
    input  wire logic                 rd_en_i,
    input  wire logic [LUT_IDX_W-1:0] rd_idx_i,
    output var  logic [LUT_DAT_W-1:0] rd_data_o
);

    logic [LUT_DAT_W-1:0] mem [LUT_DEPTH];

    // No reset on storage: host reloads it every power-up
    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem[wr_idx_i] <= wr_data_i; // R10
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_data_o <= '0;
        end else if (rd_en_i) begin
            rd_data_o <= mem[rd_idx_i];
        end
    end

endmodule : sine_table_ram

`default_nettype wire

// >>> spi_register_access_port.sv
// Serial register access port: 40-bit datagrams, register file, sine table access.
// Assumes SPI mode 0 from the host: sample on SCK rise, shift out on SCK fall.
`default_nettype none

module spi_register_access_port
    import spi_port_pkg::*;
(
    input  wire logic                          CLK_I,
    input  wire logic                          RST_I,
    input  wire logic                          SCK_I,
    input  wire logic                          CS_N_I,
    input  wire logic                          MOSI_I,
    input  wire logic [spi_port_pkg::STATUS_W-1:0] STATUS_I,
    input  wire logic                          ENC_EVENT_I,
    input  wire logic [spi_port_pkg::IRQ_W-1:0]    IRQ_EVENT_I,
    output var  logic                          MISO_O,
    output var  logic                          MISO_OE_O,
    output var  logic [spi_port_pkg::MODE_W-1:0]   MODE_O,
    output var  logic [spi_port_pkg::DATA_W-1:0]   TARGET_VEL_O,
    output var  logic                          INTERRUPT_OUT_N_O
);

    import spi_port_pkg::*;

    logic [2:0]            pins_sync;
    logic                  s_cs_n;
    logic                  s_sck;
    logic                  s_mosi;
    logic                  sck_prev_reg;
    logic                  cs_prev_reg;
    logic                  sck_rise;
    logic                  sck_fall;
    logic                  cs_fall;
    logic                  cs_rise;
    link_state_e           state_reg;
    logic [5:0]            bit_cnt_reg;
    logic [39:0]           in_reg;
    logic [39:0]           out_reg;
    logic [39:0]           resp_reg;
    logic                  commit;
    logic                  is_wr;
    logic                  is_rd;
    logic [6:0]            addr;
    logic [31:0]           wdata;
    logic [31:0]           rd_value;
    logic [MODE_W-1:0]     mode_reg;
    logic [31:0]           vel_reg;
    logic [IRQ_W-1:0]      irq_mask_reg;
    logic [IRQ_W-1:0]      irq_flags_reg;
    logic                  enc_evt_reg;
    logic [LUT_IDX_W-1:0]  lut_ptr_reg;
    logic                  lut_wr_en;
    logic                  lut_rd_en;
    logic [LUT_DAT_W-1:0]  lut_rd_data;

    spi_pin_sync #(
        .W       (3),
        .RST_VAL (PIN_IDLE)
    ) u_sync (
        .clk_i   (CLK_I),
        .rst_i   (RST_I),
        .async_i ({CS_N_I, SCK_I, MOSI_I}),
        .sync_o  (pins_sync)
    );

    assign s_cs_n = pins_sync[2];
    assign s_sck  = pins_sync[1];
    assign s_mosi = pins_sync[0];

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            sck_prev_reg <= 1'b0;
            cs_prev_reg  <= 1'b1;
        end else begin
            sck_prev_reg <= s_sck;
            cs_prev_reg  <= s_cs_n;
        end
    end

    assign sck_rise = s_sck & ~sck_prev_reg;
    assign sck_fall = ~s_sck & sck_prev_reg;
    assign cs_fall  = ~s_cs_n & cs_prev_reg;
    assign cs_rise  = s_cs_n & ~cs_prev_reg;

    // Framing: only a datagram of exactly 40 edges reaches commit
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (cs_fall) begin
                        state_reg <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (cs_rise) begin
                        state_reg <= (bit_cnt_reg == FRAME_CNT) ? ST_COMMIT : ST_IDLE; // R18
                    end
                end
                ST_COMMIT: begin
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Count saturates so overlong frames are also discarded
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            bit_cnt_reg <= '0;
        end else if (cs_fall) begin
            bit_cnt_reg <= '0;
        end else if (state_reg == ST_SHIFT && sck_rise && bit_cnt_reg != CNT_MAX) begin
            bit_cnt_reg <= bit_cnt_reg + 6'h01; // R18
        end
    end

    // MSB arrives first and ends at bit 39
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            in_reg <= '0;
        end else if (state_reg == ST_SHIFT && sck_rise) begin
            in_reg <= {in_reg[38:0], s_mosi}; // R2 R1
        end
    end

    assign commit = (state_reg == ST_COMMIT);
    assign addr   = in_reg[38:32]; // R4
    assign wdata  = in_reg[31:0]; // R3
    assign is_wr  = commit & in_reg[RW_BIT]; // R5
    assign is_rd  = commit & ~in_reg[RW_BIT]; // R5 R6

    // Read mux; narrow values sit in low bits, zeros above
    always_comb begin
        rd_value = 32'h0000_0000;
        case (addr)
            ADDR_MODE:    rd_value = {22'h0, mode_reg}; // R8
            ADDR_STATUS:  rd_value = {27'h0, STATUS_I}; // R9
            ADDR_ENC_EVT: rd_value = {31'h0, enc_evt_reg};
            ADDR_IRQ_MSK: rd_value = {24'h000000, irq_mask_reg};
            ADDR_IRQ_FLG: rd_value = {24'h000000, irq_flags_reg};
            ADDR_LUT_RD:  rd_value = {20'h00000, lut_rd_data}; // R12
            ADDR_TYPE:    rd_value = TYPE_VERSION; // R14
            default:      rd_value = 32'h0000_0000;
        endcase
    end

    // Writes are taken from commit only; read data bits never touch state
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            mode_reg     <= MODE_RST;
            vel_reg      <= VEL_RST;
            irq_mask_reg <= IRQ_MSK_RST;
        end else if (is_wr) begin
            case (addr)
                ADDR_MODE:    mode_reg     <= wdata[MODE_W-1:0]; // R16 R7
                ADDR_VEL:     vel_reg      <= wdata; // R9
                ADDR_IRQ_MSK: irq_mask_reg <= wdata[IRQ_W-1:0];
                default:      mode_reg     <= mode_reg;
            endcase
        end
    end

    // Read-clear flag; a new event in the clearing cycle survives
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            enc_evt_reg <= 1'b0;
        end else if (is_rd && addr == ADDR_ENC_EVT) begin
            enc_evt_reg <= ENC_EVENT_I; // R17
        end else begin
            enc_evt_reg <= enc_evt_reg | ENC_EVENT_I;
        end
    end

    // Write-clear flags; set beats clear
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            irq_flags_reg <= '0;
        end else if (is_wr && addr == ADDR_IRQ_FLG) begin
            irq_flags_reg <= IRQ_EVENT_I; // R17
        end else begin
            irq_flags_reg <= irq_flags_reg | IRQ_EVENT_I;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            INTERRUPT_OUT_N_O <= 1'b1;
        end else begin
            INTERRUPT_OUT_N_O <= ~|(irq_flags_reg & irq_mask_reg); // R15
        end
    end

    // Table pointer auto-increments so a full load needs no re-addressing
    assign lut_wr_en = is_wr && addr == ADDR_LUT_WR; // R11
    assign lut_rd_en = is_rd && addr == ADDR_LUT_RD; // R11 R13

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            lut_ptr_reg <= '0;
        end else if (is_wr && addr == ADDR_LUT_PTR) begin
            lut_ptr_reg <= wdata[LUT_IDX_W-1:0];
        end else if (lut_wr_en || lut_rd_en) begin
            lut_ptr_reg <= lut_ptr_reg + 13'h0001;
        end
    end

    sine_table_ram u_lut (
        .clk_i     (CLK_I),
        .rst_i     (RST_I),
        .wr_en_i   (lut_wr_en),
        .wr_idx_i  (lut_ptr_reg),
        .wr_data_i (wdata[LUT_DAT_W-1:0]),
        .rd_en_i   (lut_rd_en),
        .rd_idx_i  (lut_ptr_reg),
        .rd_data_o (lut_rd_data)
    );

    // Response is built at commit, sent during the next datagram
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            resp_reg <= '0;
        end else if (commit) begin
            resp_reg <= is_rd ? {8'h00, rd_value} : 40'h00_0000_0000; // R19 R12
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            out_reg <= '0;
        end else if (cs_fall) begin
            out_reg <= resp_reg;
        end else if (state_reg == ST_SHIFT && sck_fall) begin
            out_reg <= {out_reg[38:0], 1'b0}; // R19 R2
        end
    end

    // One extra cycle of latency, well inside a half SCK period
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            MISO_O    <= 1'b0;
            MISO_OE_O <= 1'b0;
        end else begin
            MISO_O    <= out_reg[39];
            MISO_OE_O <= ~s_cs_n;
        end
    end

    assign MODE_O       = mode_reg;
    assign TARGET_VEL_O = vel_reg;

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);

    AST_FRAME_LEN: assert property ( // R18
        commit |-> $past(bit_cnt_reg) == FRAME_CNT)
        else $error("commit without a 40-bit frame");

    AST_SHORT_DROP: assert property ( // R18
        (state_reg == ST_SHIFT && cs_rise && bit_cnt_reg != FRAME_CNT) |=> state_reg == ST_IDLE)
        else $error("incomplete frame not discarded");

    AST_MSB_FIRST: assert property ( // R2
        (state_reg == ST_SHIFT && sck_rise) |=> in_reg[0] == $past(s_mosi)
            && in_reg[39:1] == $past(in_reg[38:0]))
        else $error("serial input not shifted MSB first");

    AST_WRITE_MODE: assert property ( // R5
        (is_wr && addr == ADDR_MODE) |=> mode_reg == $past(in_reg[9:0]))
        else $error("mode write not stored");

    AST_READ_IGNORES: assert property ( // R7
        is_rd |=> $stable(mode_reg) && $stable(vel_reg) && $stable(irq_mask_reg))
        else $error("read datagram changed a register");

    AST_TYPE_CODE: assert property ( // R14
        (is_rd && addr == ADDR_TYPE) |=> resp_reg[31:0] == TYPE_VERSION)
        else $error("type code wrong");

    AST_READ_CLEAR: assert property ( // R17
        (is_rd && addr == ADDR_ENC_EVT && !ENC_EVENT_I) |=> !enc_evt_reg)
        else $error("read-clear flag not cleared");

    AST_IRQ_LOW: assert property ( // R15
        (|(irq_flags_reg & irq_mask_reg)) |=> !INTERRUPT_OUT_N_O)
        else $error("interrupt line not driven low");

    AST_LUT_LATE: assert property ( // R12
        (is_rd && addr == ADDR_LUT_RD) |=> resp_reg[31:0] == {20'h00000, $past(lut_rd_data)})
        else $error("table read not one datagram late");

    AST_RIGHT_ALIGN: assert property ( // R8
        (is_rd && addr == ADDR_STATUS) |=> resp_reg[31:5] == 27'h0)
        else $error("status not right aligned");

    AST_MISO_SHIFT: assert property ( // R19
        (state_reg == ST_SHIFT && sck_fall && !cs_fall) |=> out_reg[39:1] == $past(out_reg[38:0])
            ##1 MISO_O == $past(out_reg[39]))
        else $error("response not shifted out");

    COV_WRITE: cover property (is_wr && addr == ADDR_MODE);
    COV_LUT_RD: cover property (lut_rd_en ##[1:400] lut_rd_en);
    COV_SHORT: cover property (state_reg == ST_SHIFT && cs_rise && bit_cnt_reg != FRAME_CNT);
    COV_IRQ: cover property ($fell(INTERRUPT_OUT_N_O));

endmodule : spi_register_access_port

`default_nettype wire

// >>> spi_host_model.sv
// Host master model driving the 40-bit serial register link in mode 0.
// Assumes the block's clock is fed in; pins change on its falling edge.
`default_nettype none

module spi_host_model (
    input  wire logic clk_i,
    input  wire logic miso_i,
    output var  logic sck_o,
    output var  logic cs_n_o,
    output var  logic mosi_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sck_o  = 1'b0; // Idle low, still between frames
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end

    task automatic half(input int n);
        repeat (4 * n) @(negedge clk_i); // 16 ns half period
    endtask : half

    // Sends nbits MSB first; answer bits taken just before each fall
    task automatic xfer(input logic [39:0] tx, input int nbits, input bit slow,
                        output logic [39:0] rx);
        rx = 40'h00_0000_0000;
        @(negedge clk_i);
        cs_n_o = 1'b0;
        half(2);
        for (int i = 0; i < nbits; i++) begin
            mosi_o = tx[39 - (i % 40)];
            half(1);
            sck_o = 1'b1;
            half(1);
            rx = {rx[38:0], miso_i};
            sck_o = 1'b0;
            if (slow && (i % 8 == 7)) begin
                half(6); // Stall between bytes
            end
        end
        half(1);
        cs_n_o = 1'b1;
        mosi_o = ~mosi_o; // Released line must not keep its last value
        half(4);
    endtask : xfer

    // Register access; parameters only set this way
    task automatic access(input bit wr, input logic [6:0] addr, input logic [31:0] data,
                          input int nbits, input bit slow, output logic [39:0] rx);
        logic [7:0] hdr;
        hdr = wr ? 8'h80 + {1'b0, addr} : {1'b0, addr};
        xfer({hdr, wr ? data : 32'h0000_0000}, nbits, slow, rx);
    endtask : access

endmodule : spi_host_model

`default_nettype wire

// >>> tb.sv
// Self-checking bench for the serial register access port.
// Assumes the host model in spi_host_model.sv drives the link.
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import spi_port_pkg::*;

    logic                clk;
    logic                rst;
    logic                sck;
    logic                cs_n;
    logic                mosi;
    logic                miso;
    logic                miso_oe;
    logic                miso_wire;
    logic                miso_last = 1'b0;
    logic                enc_evt;
    logic                int_n;
    logic [STATUS_W-1:0] status;
    logic [IRQ_W-1:0]    irq_evt;
    logic [MODE_W-1:0]   mode;
    logic [DATA_W-1:0]   vel;
    logic [39:0]         rx;
    int                  mismatches = 0;
    int                  num_checks = 0;

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    spi_register_access_port spi_register_access_port_i (
        .CLK_I(clk), .RST_I(rst), .SCK_I(sck), .CS_N_I(cs_n), .MOSI_I(mosi),
        .STATUS_I(status), .ENC_EVENT_I(enc_evt), .IRQ_EVENT_I(irq_evt),
        .MISO_O(miso), .MISO_OE_O(miso_oe), .MODE_O(mode), .TARGET_VEL_O(vel),
        .INTERRUPT_OUT_N_O(int_n)
    );

    spi_host_model spi_host_model_i (
        .clk_i(clk), .miso_i(miso_wire), .sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi)
    );

    // Undriven line shows the inverse of its last level
    always @(posedge clk) if (miso_oe) miso_last <= miso;
    assign miso_wire = miso_oe ? miso : ~miso_last;

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic acc(input bit wr, input logic [6:0] a, input logic [31:0] d);
        spi_host_model_i.access(wr, a, d, 40, 1'b0, rx);
    endtask : acc

    // Answer arrives in the following frame; filler reads the code register
    task automatic rd(input logic [6:0] a, input logic [31:0] exp, input string what);
        acc(1'b0, a, 32'h0000_0000);
        acc(1'b0, ADDR_TYPE, 32'h0000_0000);
        chk(what, exp, rx[31:0]);
        chk("answer header", 32'h0000_0000, {24'h00_0000, rx[39:32]});
    endtask : rd

    task automatic t_reset();
        chk("mode", {22'h0, MODE_RST}, {22'h0, mode});
        chk("velocity", VEL_RST, vel);
        chk("interrupt", 32'h0000_0001, {31'h0, int_n});
        chk("miso enable idle", 32'h0000_0000, {31'h0, miso_oe});
        rd(ADDR_TYPE, TYPE_VERSION, "type code");
    endtask : t_reset

    task automatic t_regs();
        acc(1'b1, ADDR_MODE, 32'hFFFF_FFFF);
        chk("mode", 32'h0000_03FF, {22'h0, mode});
        rd(ADDR_MODE, 32'h0000_03FF, "mode readback");
        acc(1'b1, ADDR_VEL, 32'h89AB_CDEF);
        chk("velocity", 32'h89AB_CDEF, vel);
        rd(ADDR_VEL, 32'h0000_0000, "write-only read");
        spi_host_model_i.xfer({1'b0, ADDR_MODE, 32'h0000_0155}, 40, 1'b1, rx);
        chk("mode after read", 32'h0000_03FF, {22'h0, mode});
        acc(1'b1, ADDR_TYPE, 32'h0000_0000);
        rd(ADDR_TYPE, TYPE_VERSION, "read-only code");
    endtask : t_regs

    task automatic t_frame();
        spi_host_model_i.access(1'b1, ADDR_VEL, 32'h0000_1234, 39, 1'b0, rx);
        chk("short frame", 32'h89AB_CDEF, vel);
        spi_host_model_i.access(1'b1, ADDR_VEL, 32'h0000_1234, 41, 1'b0, rx);
        chk("long frame", 32'h89AB_CDEF, vel);
        spi_host_model_i.access(1'b1, ADDR_VEL, 32'h0000_1234, 40, 1'b1, rx);
        chk("slow frame", 32'h0000_1234, vel);
    endtask : t_frame

    task automatic t_status();
        @(negedge clk);
        status = 5'h15;
        rd(ADDR_STATUS, 32'h0000_0015, "status");
        enc_evt = 1'b1;
        @(negedge clk);
        enc_evt = 1'b0;
        rd(ADDR_ENC_EVT, 32'h0000_0001, "event flag");
        rd(ADDR_ENC_EVT, 32'h0000_0000, "event cleared");
    endtask : t_status

    task automatic t_irq();
        @(negedge clk);
        irq_evt = 8'h04;
        @(negedge clk);
        irq_evt = 8'h00;
        repeat (4) @(negedge clk);
        chk("masked interrupt", 32'h0000_0001, {31'h0, int_n});
        acc(1'b1, ADDR_IRQ_MSK, 32'h0000_0004);
        chk("interrupt", 32'h0000_0000, {31'h0, int_n});
        rd(ADDR_IRQ_FLG, 32'h0000_0004, "flags");
        rd(ADDR_IRQ_MSK, 32'h0000_0004, "mask");
        acc(1'b1, ADDR_IRQ_FLG, 32'h0000_0000);
        chk("interrupt released", 32'h0000_0001, {31'h0, int_n});
        rd(ADDR_IRQ_FLG, 32'h0000_0000, "flags cleared");
    endtask : t_irq

    // Last two entries, then wrap; extra read collects the final value
    task automatic t_table();
        acc(1'b1, ADDR_LUT_PTR, 32'h0000_1FFE);
        acc(1'b1, ADDR_LUT_WR, 32'hFFFF_FABC);
        acc(1'b1, ADDR_LUT_WR, 32'h0000_0123);
        acc(1'b1, ADDR_LUT_PTR, 32'h0000_1FFE);
        acc(1'b0, ADDR_LUT_RD, 32'h0000_0000);
        acc(1'b0, ADDR_LUT_RD, 32'h0000_0000);
        chk("table first", 32'h0000_0000, rx[31:0]);
        acc(1'b0, ADDR_LUT_RD, 32'h0000_0000);
        chk("table 8190", 32'h0000_0ABC, rx[31:0]);
        acc(1'b0, ADDR_TYPE, 32'h0000_0000);
        chk("table 8191", 32'h0000_0123, rx[31:0]);
    endtask : t_table

    initial begin
        #300us;
        mismatches++;
        $display("Watchdog expired");
        conclude();
    end

    initial begin
        rst     = 1'b1;
        status  = 5'h00;
        enc_evt = 1'b0;
        irq_evt = 8'h00;
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        t_reset();
        t_regs();
        t_frame();
        t_status();
        t_irq();
        t_table();
        conclude();
    end

endmodule : tb

`default_nettype wire
